/* design/ums_fifo.sv */
`default_nettype none
module ums_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic                       aclk,      // clock
    input  wire logic                       aresetn,   // sync reset, low
    input  wire logic                       in_valid,  // word offered
    output logic                            in_ready,  // room for a word
    input  wire logic [WIDTH-1:0]           in_data,   // word in
    output logic                            out_valid, // word available
    input  wire logic                       out_ready, // word taken
    output logic [WIDTH-1:0]                out_data,  // oldest word
    output logic [$clog2(DEPTH+1)-1:0]      level      // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [CW-1:0]               cnt;
    } ums_fifo_s;

    ums_fifo_s q;
    ums_fifo_s d;
    logic      push;
    logic      pop;

    assign in_ready  = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];
    assign level     = q.cnt;

    always_comb begin
        d    = q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + CW'(1);
        end else if (pop && !push) begin
            d.cnt = q.cnt - CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        q.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* design/ums_pkg.sv */
`default_nettype none
package ums_pkg;
    typedef enum logic {RX_IDLE, RX_SHIFT} ums_rx_e;
    typedef enum logic {TX_IDLE, TX_SHIFT} ums_tx_e;
    typedef struct packed {
        logic        aw_got;
        logic [5:0]  aw_idx;
        logic        w_got;
        logic [31:0] w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        mode3;
        logic        rx_en;
        logic        mp_en;
        logic        tx_nb;
        logic        dbl;
        logic        rx_done;
        logic        tx_done;
        logic        rx_nb;
        logic [7:0]  reload;
        logic [7:0]  rx_buf;
        logic [1:0]  pre_cnt;
        logic [7:0]  t1_cnt;
        logic        ovf_half;
        logic [1:0]  m2_cnt;
        ums_tx_e     tx_state;
        logic [3:0]  tx_div;
        logic [3:0]  tx_bits;
        logic [9:0]  tx_shift;
        logic        txd;
        ums_rx_e     rx_state;
        logic [3:0]  rx_div;
        logic [3:0]  rx_bits;
        logic [1:0]  rx_samp;
        logic [8:0]  rx_shift;
        logic        rx_prev;
    } ums_state_s;
endpackage
`default_nettype wire

/* design/ums_regs.svh */
`ifndef UMS_REGS_SVH
`define UMS_REGS_SVH
`define UMS_OFS_CTRL    6'h00
`define UMS_OFS_BUF     6'h01
`define UMS_OFS_RELOAD  6'h02
`define UMS_OFS_STAT    6'h03
`define UMS_CTRL_MODE3  0
`define UMS_CTRL_RXEN   1
`define UMS_CTRL_MPEN   2
`define UMS_CTRL_TXNB   3
`define UMS_CTRL_DBL    4
`define UMS_CTRL_RXDONE 5
`define UMS_CTRL_TXDONE 6
`define UMS_CTRL_RXNB   7
`define UMS_STAT_RXBUSY 0
`define UMS_STAT_TXBUSY 1
`define UMS_STAT_FULL   2
`define UMS_STAT_LVL    4
`define UMS_RELOAD_RST  8'h00
`define UMS_OVS_LAST    4'hf
`define UMS_SAMP_A      4'h7
`define UMS_SAMP_B      4'h8
`define UMS_SAMP_C      4'h9
`define UMS_FRAME_LAST  4'ha
`define UMS_T1_PRE_LAST 2'h3
`define UMS_RESP_OKAY   2'h0
`define UMS_RESP_SLVERR 2'h2
`endif

/* design/ums_uart.sv */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "ums_regs.svh"
`default_nettype none
module ums_uart
    import ums_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        aclk,     // 25 MHz clock
    input  wire logic        aresetn,  // sync reset, low
    input  wire logic [7:0]  awaddr,   // write address
    input  wire logic        awvalid,  // write address valid
    output logic             awready,  // write address ready
    input  wire logic [31:0] wdata,    // write data
    input  wire logic [3:0]  wstrb,    // write strobes
    input  wire logic        wvalid,   // write data valid
    output logic             wready,   // write data ready
    output logic [1:0]       bresp,    // write response
    output logic             bvalid,   // write response valid
    input  wire logic        bready,   // write response ready
    input  wire logic [7:0]  araddr,   // read address
    input  wire logic        arvalid,  // read address valid
    output logic             arready,  // read address ready
    output logic [31:0]      rdata,    // read data
    output logic [1:0]       rresp,    // read response
    output logic             rvalid,   // read data valid
    input  wire logic        rready,   // read data ready
    input  wire logic        rxd,      // serial receive line
    output logic             txd       // serial transmit line
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    ums_state_s    q;
    ums_state_s    d;
    logic          tick16;
    logic          t1_ovf;
    logic          tx_roll;
    logic          tx_start;
    logic          tx_set;
    logic          rx_mid;
    logic          vote;
    logic          stop_mid;
    logic          mp_act;
    logic          accept;
    logic          rx_clr;
    logic          tx_clr;
    logic          is_buf;
    logic          wr_go;
    logic          fifo_in_valid;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [8:0]    fifo_out_data;
    logic [LW-1:0] fifo_level;
    logic [31:0]   rd_val;
    logic [1:0]    rd_resp;

    // ==========================================
    // transmit queue
    // ==========================================
    ums_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({q.tx_nb, q.w_data[7:0]}),
        .out_valid (fifo_out_valid),
        .out_ready (tx_start),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    assign awready = !q.aw_got && !q.bvalid;
    assign wready  = !q.w_got && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rresp   = q.rresp;
    assign rdata   = q.rdata;
    assign txd     = q.txd;

    // ==========================================
    // read mux
    // ==========================================
    always_comb begin
        rd_val  = 32'h0000_0000;
        rd_resp = `UMS_RESP_OKAY;
        unique case (araddr[7:2])
            `UMS_OFS_CTRL: begin
                rd_val[`UMS_CTRL_MODE3]  = q.mode3;
                rd_val[`UMS_CTRL_RXEN]   = q.rx_en;
                rd_val[`UMS_CTRL_MPEN]   = q.mp_en;
                rd_val[`UMS_CTRL_TXNB]   = q.tx_nb;
                rd_val[`UMS_CTRL_DBL]    = q.dbl;
                rd_val[`UMS_CTRL_RXDONE] = q.rx_done;
                rd_val[`UMS_CTRL_TXDONE] = q.tx_done;
                rd_val[`UMS_CTRL_RXNB]   = q.rx_nb;
            end
            `UMS_OFS_BUF: begin
                rd_val[7:0] = q.rx_buf;
            end
            `UMS_OFS_RELOAD: begin
                rd_val[7:0] = q.reload;
            end
            `UMS_OFS_STAT: begin
                rd_val[`UMS_STAT_RXBUSY] = (q.rx_state == RX_SHIFT);
                rd_val[`UMS_STAT_TXBUSY] = (q.tx_state == TX_SHIFT);
                rd_val[`UMS_STAT_FULL]   = !fifo_in_ready;
                rd_val[`UMS_STAT_LVL +: LW] = fifo_level;
            end
            default: begin
                rd_resp = `UMS_RESP_SLVERR;
            end
        endcase
    end

    // ==========================================
    // next state
    // ==========================================
    always_comb begin
        d             = q;
        t1_ovf        = 1'b0;
        tick16        = 1'b0;
        tx_set        = 1'b0;
        rx_clr        = 1'b0;
        tx_clr        = 1'b0;

        // bus writes: address and data may come in either order
        is_buf        = (q.aw_idx == `UMS_OFS_BUF);
        fifo_in_valid = q.aw_got && q.w_got && is_buf && q.w_lane0;
        // a full queue holds the write response back; that is the back-pressure
        wr_go         = q.aw_got && q.w_got && !(fifo_in_valid && !fifo_in_ready);
        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.aw_idx = awaddr[7:2];
        end
        if (wvalid && wready) begin
            d.w_got   = 1'b1;
            d.w_data  = wdata;
            d.w_lane0 = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `UMS_RESP_OKAY;
            unique case (q.aw_idx)
                `UMS_OFS_CTRL: begin
                    if (q.w_lane0) begin
                        d.mode3 = q.w_data[`UMS_CTRL_MODE3];
                        d.rx_en = q.w_data[`UMS_CTRL_RXEN];
                        d.mp_en = q.w_data[`UMS_CTRL_MPEN];
                        d.tx_nb = q.w_data[`UMS_CTRL_TXNB];
                        d.dbl   = q.w_data[`UMS_CTRL_DBL];
                        rx_clr  = q.w_data[`UMS_CTRL_RXDONE];
                        tx_clr  = q.w_data[`UMS_CTRL_TXDONE];
                    end
                end
                `UMS_OFS_BUF: begin
                end
                `UMS_OFS_RELOAD: begin
                    if (q.w_lane0) begin
                        d.reload = q.w_data[7:0];
                    end
                end
                `UMS_OFS_STAT: begin
                end
                default: begin
                    d.bresp = `UMS_RESP_SLVERR;
                end
            endcase
        end

        // bus reads answer one cycle after the address is taken
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_val;
            d.rresp  = rd_resp;
        end

        // ==========================================
        // sample-rate ticks, sixteen per bit
        // ==========================================
        d.m2_cnt = q.m2_cnt + 2'h1;
        if (q.pre_cnt == `UMS_T1_PRE_LAST) begin
            d.pre_cnt = 2'h0;
            if (q.t1_cnt == 8'hff) begin
                t1_ovf   = 1'b1;
                d.t1_cnt = q.reload;
            end else begin
                d.t1_cnt = q.t1_cnt + 8'h01;
            end
        end else begin
            d.pre_cnt = q.pre_cnt + 2'h1;
        end
        if (t1_ovf) begin
            d.ovf_half = ~q.ovf_half;
        end
        if (q.mode3) begin
            // halving the overflows without the double-rate bit gives the /32 form
            tick16 = t1_ovf && (q.dbl || q.ovf_half);
        end else begin
            tick16 = q.dbl ? q.m2_cnt[0] : (q.m2_cnt == 2'h3);
        end

        // ==========================================
        // transmitter
        // ==========================================
        tx_roll = tick16 && (q.tx_div == `UMS_OVS_LAST);
        if (tick16) begin
            d.tx_div = q.tx_div + 4'h1;
        end
        // a queued byte follows a finished stop bit without an idle gap
        tx_start = tx_roll && fifo_out_valid &&
                   (q.tx_state == TX_IDLE || q.tx_bits == `UMS_FRAME_LAST);
        if (tx_start) begin
            d.tx_state = TX_SHIFT;
            d.txd      = 1'b0;
            d.tx_bits  = 4'h0;
            d.tx_shift = {1'b1, fifo_out_data};
        end else if (tx_roll && q.tx_state == TX_SHIFT) begin
            if (q.tx_bits == `UMS_FRAME_LAST) begin
                d.tx_state = TX_IDLE;
            end else begin
                d.txd      = q.tx_shift[0];
                d.tx_shift = {1'b1, q.tx_shift[9:1]};
                d.tx_bits  = q.tx_bits + 4'h1;
                tx_set     = (d.tx_bits == `UMS_FRAME_LAST);
            end
        end
        d.tx_done = (q.tx_done && !tx_clr) || tx_set;

        // ==========================================
        // receiver
        // ==========================================
        rx_mid   = tick16 && (q.rx_state == RX_SHIFT) && (q.rx_div == `UMS_SAMP_C);
        vote     = (q.rx_samp[1] && q.rx_samp[0]) || (q.rx_samp[1] && rxd) ||
                   (q.rx_samp[0] && rxd);
        stop_mid = rx_mid && (q.rx_bits == `UMS_FRAME_LAST);
        // only the eleven-bit modes exist here, so the enable bit alone decides
        mp_act   = q.mp_en;
        accept   = stop_mid && !q.rx_done &&
                   (!mp_act || (vote && q.rx_shift[8]));
        d.rx_prev = rxd;
        unique case (q.rx_state)
            RX_IDLE: begin
                if (q.rx_en && q.rx_prev && !rxd) begin
                    d.rx_state = RX_SHIFT;
                    d.rx_div   = 4'h0;
                    d.rx_bits  = 4'h0;
                end
            end
            RX_SHIFT: begin
                if (tick16) begin
                    d.rx_div = q.rx_div + 4'h1;
                end
                if (tick16 && (q.rx_div == `UMS_SAMP_A || q.rx_div == `UMS_SAMP_B)) begin
                    d.rx_samp = {q.rx_samp[0], rxd};
                end
                if (rx_mid) begin
                    d.rx_bits = q.rx_bits + 4'h1;
                    if (q.rx_bits == 4'h0 && vote) begin
                        d.rx_state = RX_IDLE;
                    end else if (q.rx_bits != 4'h0 && !stop_mid) begin
                        d.rx_shift = {vote, q.rx_shift[8:1]};
                    end
                    if (stop_mid) begin
                        d.rx_state = RX_IDLE;
                    end
                end
            end
        endcase
        if (accept) begin
            d.rx_buf = q.rx_shift[7:0];
            d.rx_nb  = q.rx_shift[8];
        end
        // a dropped frame leaves buffer and ninth-bit flag as they were
        d.rx_done = (q.rx_done && !rx_clr) || accept;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q          <= '0;
            q.reload   <= `UMS_RELOAD_RST;
            q.txd      <= 1'b1;
            q.rx_prev  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // checks
    // ==========================================
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_accept_sets_done:
    assert property (accept |=> q.rx_done && q.rx_buf == $past(q.rx_shift[7:0]) &&
                     q.rx_nb == $past(q.rx_shift[8]))
        else $error("accepted frame not stored");

    a_reject_holds_buf:
    assert property (stop_mid && !accept |=> $stable(q.rx_buf) && $stable(q.rx_nb))
        else $error("dropped frame changed buffer");

    a_reject_no_done:
    assert property (stop_mid && q.rx_done |=> $stable(q.rx_buf) && $stable(q.rx_nb))
        else $error("frame accepted over a full buffer");

    a_rx_idle_after:
    assert property (stop_mid |=> q.rx_state == RX_IDLE ##1 q.rx_state == RX_IDLE || !$past(rxd))
        else $error("receiver not idle after stop");

    a_filter_ninth:
    assert property (stop_mid && q.mp_en && !q.rx_shift[8] |=> $stable(q.rx_buf))
        else $error("data frame passed the filter");

    a_false_start:
    assert property (rx_mid && q.rx_bits == 4'h0 && vote |=> q.rx_state == RX_IDLE)
        else $error("false start not aborted");

    a_tx_start_bit:
    assert property (tx_start |=> !q.txd && q.tx_state == TX_SHIFT && q.tx_bits == 4'h0)
        else $error("start bit not placed");

    a_tx_done_stop:
    assert property ($rose(q.tx_done) |-> q.txd && q.tx_bits == `UMS_FRAME_LAST)
        else $error("transmit done not at stop bit");

    a_tx_idle_high:
    assert property (q.tx_state == TX_IDLE |-> q.txd)
        else $error("line low while idle");

    a_mode2_rate:
    assert property (!q.mode3 && q.dbl && tick16 ##1 (!q.mode3 && q.dbl) ##1 (!q.mode3 && q.dbl) |->
                     tick16 && !$past(tick16))
        else $error("mode 2 double rate tick wrong");

    a_reset_state:
    assert property (disable iff (1'b0) !aresetn |=> !q.rx_done && !q.tx_done && !q.mp_en &&
                     !q.rx_nb && q.txd && q.rx_state == RX_IDLE)
        else $error("reset state wrong");
endmodule
`default_nettype wire

/* test/uart_ninth_bit_multiproc_tb.sv */
`default_nettype none
module uart_ninth_bit_multiproc_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, rxd, txd;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] bit_cyc = 16'h0020; // mode 2 with the double-rate bit: 32 clocks a bit
    int          fails = 0, n_tests = 0, cyc = 0;
    always #20 aclk = ~aclk;
    ums_uart #(.FIFO_DEPTH(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd));
    ums_node_model u_node (.aclk(aclk), .bit_cyc(bit_cyc), .txd(txd), .rxd(rxd));
    // =====================================
    // bus tasks
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        axi_rd(a);
        chk(rd, {24'h0, exp});
        chk({30'h0, rs}, 32'h0);
    endtask
    task automatic wait_tx(input int n);
        while (u_node.n_rx < n) @(posedge aclk);
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            summarize;
        end
    end
    // =====================================
    // tests
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk_reg(8'h00, 8'h00);
        chk({31'h0, txd}, 32'h1);
        chk_reg(8'h04, 8'h00);
        $display("test reset done");
        axi_wr(8'h00, 8'h18);
        axi_wr(8'h04, 8'ha5);
        wait_tx(1);
        chk({u_node.got_stop, u_node.got_nb, u_node.got_byte}, 32'h3a5);
        chk_reg(8'h00, 8'h58);
        axi_wr(8'h00, 8'h58);
        chk_reg(8'h00, 8'h18);
        $display("test transmit done");
        axi_wr(8'h00, 8'h12);
        u_node.send(8'h3c, 1'b1, 1'b0);
        chk_reg(8'h04, 8'h3c);
        chk_reg(8'h00, 8'hb2);
        u_node.send(8'h55, 1'b0, 1'b1);
        chk_reg(8'h04, 8'h3c);
        chk_reg(8'h00, 8'hb2);
        $display("test receive done");
        axi_wr(8'h00, 8'h36);
        chk_reg(8'h00, 8'h96);
        u_node.send(8'h66, 1'b0, 1'b1);
        u_node.send(8'ha1, 1'b1, 1'b0);
        chk_reg(8'h04, 8'h3c);
        chk_reg(8'h00, 8'h96);
        u_node.send(8'ha2, 1'b1, 1'b1);
        chk_reg(8'h04, 8'ha2);
        chk_reg(8'h00, 8'hb6);
        axi_wr(8'h00, 8'h32);
        u_node.send(8'h77, 1'b0, 1'b1);
        chk_reg(8'h04, 8'h77);
        chk_reg(8'h00, 8'h32);
        u_node.glitch(4);
        chk_reg(8'h0c, 8'h00);
        $display("test filter done");
        axi_wr(8'h08, 8'hfe);
        // the new reload only takes effect at the next overflow of the free-running timer
        repeat (1100) @(posedge aclk);
        axi_wr(8'h00, 8'h33);
        bit_cyc <= 16'd128;
        u_node.send(8'hc3, 1'b1, 1'b1);
        chk_reg(8'h04, 8'hc3);
        chk_reg(8'h00, 8'hb3);
        // without the double-rate bit only every second overflow ticks
        axi_wr(8'h00, 8'h21);
        bit_cyc <= 16'd256;
        axi_wr(8'h04, 8'h5a);
        wait_tx(2);
        chk({u_node.got_stop, u_node.got_nb, u_node.got_byte}, 32'h25a);
        $display("test mode3 done");
        axi_wr(8'h00, 8'h00);
        bit_cyc <= 16'd64;
        // the tenth write stalls until the second queued word leaves
        for (int i = 0; i < 10; i++) axi_wr(8'h04, 8'h10 + i[7:0]);
        chk_reg(8'h0c, 8'h86);
        wait_tx(12);
        chk({24'h0, u_node.got_byte}, 32'h19);
        repeat (100) @(posedge aclk);
        chk_reg(8'h0c, 8'h00);
        $display("test queue done");
        axi_wr(8'h10, 8'h01);
        chk({30'h0, rs}, 32'h2);
        axi_rd(8'h10);
        chk({30'h0, rs}, 32'h2);
        $display("test unmapped done");
        summarize;
    end
endmodule
`default_nettype wire

/* test/ums_node_model.sv */
`default_nettype none
module ums_node_model (
    input  wire logic        aclk,    // clock
    input  wire logic [15:0] bit_cyc, // aclk cycles per bit
    input  wire logic        txd,     // line from the block
    output logic             rxd      // line into the block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] sh;
    logic [7:0] got_byte;
    logic       got_nb;
    logic       got_stop;
    int         n_rx;
    initial begin
        rxd = 1'b1;
        n_rx = 0;
    end
    // =====================================
    // sender: start, d0..d7, ninth, stop
    task automatic send(input logic [7:0] d, input logic nb, input logic stp);
        logic [10:0] fr;
        fr = {stp, nb, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge aclk);
            rxd <= fr[i];
            repeat (bit_cyc - 1) @(posedge aclk);
        end
        // a bad stop bit would hide the next start edge, so idle a bit high
        @(posedge aclk);
        rxd <= 1'b1;
        repeat (bit_cyc - 1) @(posedge aclk);
    endtask
    // a short low pulse that the start-bit vote must reject
    task automatic glitch(input int n);
        @(posedge aclk);
        rxd <= 1'b0;
        repeat (n) @(posedge aclk);
        rxd <= 1'b1;
        repeat (bit_cyc) @(posedge aclk);
    endtask
    // =====================================
    // receiver: samples the middle of each bit after the start bit
    always begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            repeat (bit_cyc) @(posedge aclk);
            sh[i] = txd;
        end
        got_byte = sh[7:0];
        got_nb = sh[8];
        got_stop = sh[9];
        n_rx = n_rx + 1;
    end
endmodule
`default_nettype wire
